// ---- logic/fsr_top.sv ----
// serial flash command decoder: status write, status read and single/dual reads
//
// Functional notes
// R1: status write needs write-enable latch set first
// R2: host sends opcode then one data byte
// R3: status write never changes busy/latch bits
// R4: status write only if select rises after bit eight
// R5: select rise starts timed cycle, busy held high
// R6: status read answered while write cycle runs
// R7: cycle end clears the write-enable latch
// R8: status write updates protect bits and permanent lock
// R9: permanent lock freezes protect, otp lock, itself
// R10: otp mode: lock, top/bottom, size set once; with volatile status enabled, top/bottom and size take the data byte
// R11: normal read: 24-bit address, data on falls
// R12: address increments per byte, wraps to zero
// R13: select high ends read, drivers released
// R14: reads rejected while any write cycle busy
// R15: fast read: address plus one dummy byte
// R16: dual output: eight dummy clocks, two-bit data
// R17: dummy inputs ignored; host releases line zero
// R18: dual io: address, dummy, data two bits
// R19: no modifying command while latch is clear
// R20: upper bit of pair on line one
// R21: dual io uses four dummy clocks
`timescale 1ns/10ps
`default_nettype none

module fsr_top #(
  parameter int unsigned WCYCLES = fsr_pkg::T_W_CYC
) (
  input  wire logic                         clk_i,
  input  wire logic                         nrst_i,
  input  wire logic                         cs_n_i,
  input  wire logic                         sck_i,
  input  wire logic                         io_line_zero_i,
  input  wire logic                         io_line_one_i,
  output logic                              io_line_zero_o,
  output logic                              io_line_zero_oe_o,
  output logic                              io_line_one_o,
  output logic                              io_line_one_oe_o,
  output logic [fsr_pkg::ADDR_W-1:0]        mem_addr_o,
  input  wire logic [fsr_pkg::BYTE_W-1:0]   mem_rdata_i,
  input  wire logic                         otp_mode_i,
  input  wire logic                         volatile_sr_en_i,
  input  wire logic                         ext_busy_i,
  output logic [7:0]                        status_o,
  output logic                              write_enable_latch_o,
  output logic                              write_in_progress_o,
  output logic [3:0]                        protect_level_o,
  output logic                              permanent_lock_bit_o,
  output logic                              otp_lock_o,
  output logic                              top_bottom_select_o,
  output logic                              sector_size_o
);
  import fsr_pkg::*;

  // ===========================================================================
  // opcode decoding helpers
  function automatic logic is_dual_io(input logic [7:0] op);
    return op == OP_DUAL_IO;
  endfunction : is_dual_io

  function automatic logic is_dual_out(input logic [7:0] op);
    return (op == OP_DUAL_OUT) || (op == OP_DUAL_IO);
  endfunction : is_dual_out

  function automatic logic [CNT_W-1:0] dummy_clks(input logic [7:0] op);
    logic [CNT_W-1:0] n;
    n = DUMMY_NONE;
    if ((op == OP_FAST_READ) || (op == OP_DUAL_OUT)) begin
      n = DUMMY_FAST; // R15 R16
    end else if (op == OP_DUAL_IO) begin
      n = DUMMY_DUAL_IO; // R21
    end
    return n;
  endfunction : dummy_clks

  function automatic fsr_state_t op_decode(input logic [7:0] op,
                                           input logic       write_enable_latch,
                                           input logic       busy);
    fsr_state_t s;
    s = ST_IGN;
    if (op == OP_WRITE_STATUS) begin
      s = (write_enable_latch && !busy) ? ST_WRDAT : ST_IGN; // R1 R19
    end else if (op == OP_READ_STATUS) begin
      s = ST_STAT; // R6
    end else if (op == OP_WRITE_UNLOCK) begin
      s = ST_WEN;
    end else if ((op == OP_READ) || (op == OP_FAST_READ) ||
                 (op == OP_DUAL_OUT) || (op == OP_DUAL_IO)) begin
      s = busy ? ST_IGN : ST_ADDR; // R14
    end
    return s;
  endfunction : op_decode

  // ===========================================================================
  // declarations
  fsr_state_t        state_q;
  logic              sck_q;
  logic              cs_q;
  logic              sck_rise;
  logic              sck_fall;
  logic              cs_rise;
  logic [CNT_W-1:0]  cnt_q;
  logic [CNT_W-1:0]  addr_last;
  logic [CNT_W-1:0]  dummy_n;
  logic              phase_end;
  logic [7:0]        opc_q;
  logic [7:0]        op_now;
  logic [ADDR_W-1:0] addr_q;
  logic [7:0]        wr_q;
  logic [7:0]        sh_q;
  logic [7:0]        src;
  logic [2:0]        bcnt_q;
  logic              drv_q;
  logic              out_phase;
  logic              dual_out;
  logic              load_byte;
  logic              busy_all;
  logic              write_in_progress;
  logic              wcyc_done;
  logic              write_enable_latch;
  logic              sr_wr;
  logic              wel_set;

  // ===========================================================================
  // pin edge detection; pins are already synchronous to clk_i
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sck_q <= 1'b0;
      cs_q  <= 1'b1;
    end else begin
      sck_q <= sck_i;
      cs_q  <= cs_n_i;
    end
  end

  assign sck_rise = !cs_n_i && sck_i && !sck_q;
  assign sck_fall = !cs_n_i && !sck_i && sck_q;
  assign cs_rise  = cs_n_i && !cs_q;

  // ===========================================================================
  // phase bookkeeping
  assign op_now    = {opc_q[6:0], io_line_zero_i};
  assign busy_all  = write_in_progress || ext_busy_i; // R14
  assign addr_last = is_dual_io(opc_q) ? ADDR_LAST_DUAL : ADDR_LAST_SGL; // R18 R11
  assign dummy_n   = dummy_clks(opc_q);
  assign out_phase = (state_q == ST_DATA) || (state_q == ST_STAT);
  assign dual_out  = (state_q == ST_DATA) && is_dual_out(opc_q);
  assign load_byte = sck_fall && out_phase && (bcnt_q == 3'h0);

  always_comb begin
    phase_end = 1'b0;
    if ((state_q == ST_OPC) && (cnt_q == OP_LAST)) begin
      phase_end = 1'b1;
    end else if ((state_q == ST_ADDR) && (cnt_q == addr_last)) begin
      phase_end = 1'b1;
    end else if ((state_q == ST_DUMMY) && (cnt_q == dummy_n - 1'b1)) begin
      phase_end = 1'b1;
    end
  end

  // ===========================================================================
  // decoder state; chip select high always returns to opcode collection
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q <= ST_OPC;
    end else if (cs_n_i) begin
      state_q <= ST_OPC; // R13
    end else if (sck_rise) begin
      unique case (state_q)
        ST_OPC: begin
          if (phase_end) begin
            state_q <= op_decode(op_now, write_enable_latch, busy_all);
          end
        end
        ST_ADDR: begin
          if (phase_end) begin
            state_q <= (dummy_n == DUMMY_NONE) ? ST_DATA : ST_DUMMY; // R11
          end
        end
        ST_DUMMY: begin
          if (phase_end) begin
            state_q <= ST_DATA; // R17
          end
        end
        ST_WEN: begin
          state_q <= ST_IGN;
        end
        ST_DATA,
        ST_STAT,
        ST_WRDAT,
        ST_IGN: begin
          state_q <= state_q;
        end
        default: begin
          state_q <= ST_IGN;
        end
      endcase
    end
  end

  // clock counter within a phase, saturating so overlong bytes are seen
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_q <= '0;
    end else if (cs_n_i) begin
      cnt_q <= '0;
    end else if (sck_rise) begin
      if (phase_end) begin
        cnt_q <= '0;
      end else if (cnt_q != CNT_MAX) begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      opc_q <= 8'h00;
    end else if (sck_rise && (state_q == ST_OPC)) begin
      opc_q <= op_now;
    end
  end

  // ===========================================================================
  // address: shifted in on rises, then stepped once per byte sent
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      addr_q <= ADDR_RST;
    end else if (sck_rise && (state_q == ST_ADDR)) begin
      if (is_dual_io(opc_q)) begin
        addr_q <= {addr_q[ADDR_W-3:0], io_line_one_i, io_line_zero_i}; // R18 R20
      end else begin
        addr_q <= {addr_q[ADDR_W-2:0], io_line_zero_i}; // R11
      end
    end else if (load_byte && (state_q == ST_DATA)) begin
      addr_q <= addr_q + ADDR_ONE; // R12
    end
  end

  assign mem_addr_o = addr_q;

  // ===========================================================================
  // status data byte; counts beyond eight make the write invalid
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_q <= 8'h00;
    end else if (sck_rise && (state_q == ST_WRDAT) && (cnt_q < WR_BITS)) begin
      wr_q <= {wr_q[6:0], io_line_zero_i}; // R2
    end
  end

  assign sr_wr   = cs_rise && (state_q == ST_WRDAT) && (cnt_q == WR_BITS) &&
                   write_enable_latch && !write_in_progress; // R4 R1
  assign wel_set = cs_rise && (state_q == ST_WEN) && !busy_all;

  // ===========================================================================
  // output shifter; status read repeats the live status byte
  assign src = (state_q == ST_STAT) ? status_o : mem_rdata_i;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sh_q           <= 8'h00;
      bcnt_q         <= 3'h0;
      io_line_one_o  <= 1'b0;
      io_line_zero_o <= 1'b0;
    end else if (cs_n_i) begin
      bcnt_q <= 3'h0;
    end else if (sck_fall && out_phase) begin
      if (bcnt_q == 3'h0) begin
        io_line_one_o <= src[7];
        if (dual_out) begin
          io_line_zero_o <= src[6]; // R20
          sh_q           <= {src[5:0], 2'b00};
          bcnt_q         <= BIT_LAST_DUAL; // R16 R18
        end else begin
          sh_q   <= {src[6:0], 1'b0};
          bcnt_q <= BIT_LAST_SGL; // R11
        end
      end else begin
        io_line_one_o <= sh_q[7];
        if (dual_out) begin
          io_line_zero_o <= sh_q[6]; // R20
          sh_q           <= {sh_q[5:0], 2'b00};
        end else begin
          sh_q <= {sh_q[6:0], 1'b0};
        end
        bcnt_q <= bcnt_q - 1'b1;
      end
    end
  end

  // drive starts at the first data fall, so line zero is free during dummies
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      drv_q <= 1'b0;
    end else if (cs_n_i) begin
      drv_q <= 1'b0; // R13
    end else if (sck_fall && out_phase) begin
      drv_q <= 1'b1; // R17
    end
  end

  assign io_line_one_oe_o  = drv_q;
  assign io_line_zero_oe_o = drv_q && dual_out;

  // ===========================================================================
  // write cycle timer and status register
  fsr_wcycle #(
    .CYCLES (WCYCLES)
  ) u_wcycle (
    .clk_i   (clk_i),
    .nrst_i  (nrst_i),
    .start_i (sr_wr),
    .busy_o  (write_in_progress),
    .done_o  (wcyc_done)
  );

  fsr_status u_status (
    .clk_i            (clk_i),
    .nrst_i           (nrst_i),
    .otp_mode_i       (otp_mode_i),
    .volatile_sr_en_i (volatile_sr_en_i),
    .wr_i             (sr_wr),
    .wr_data_i        (wr_q),
    .wel_set_i        (wel_set),
    .wel_clr_i        (wcyc_done),
    .wip_i            (write_in_progress),
    .status_o         (status_o),
    .wel_o            (write_enable_latch),
    .bp_o             (protect_level_o),
    .ppb_o            (permanent_lock_bit_o),
    .otp_lock_o       (otp_lock_o),
    .tb_o             (top_bottom_select_o),
    .sect_o           (sector_size_o)
  );

  assign write_enable_latch_o = write_enable_latch;
  assign write_in_progress_o  = write_in_progress;

endmodule : fsr_top
`default_nettype wire

// ---- logic/fsr_pkg.sv ----
// constants, types and opcodes shared by the status-write and read command decoder
package fsr_pkg;

  // ===========================================================================
  // widths
  localparam int unsigned ADDR_W   = 24;
  localparam int unsigned BYTE_W   = 8;
  localparam int unsigned CNT_W    = 6;
  localparam int unsigned TW_CNT_W = 24;

  // ===========================================================================
  // instruction opcodes
  localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
  localparam logic [7:0] OP_READ         = 8'h03;
  localparam logic [7:0] OP_READ_STATUS  = 8'h05;
  localparam logic [7:0] OP_WRITE_UNLOCK = 8'h06;
  localparam logic [7:0] OP_FAST_READ    = 8'h0b;
  localparam logic [7:0] OP_DUAL_OUT     = 8'h3b;
  localparam logic [7:0] OP_DUAL_IO      = 8'hbb;

  // ===========================================================================
  // phase lengths, in serial clocks (last index for opcode, address and bits; dummies and status data as counts)
  localparam logic [CNT_W-1:0] OP_LAST        = 6'h07;
  localparam logic [CNT_W-1:0] ADDR_LAST_SGL  = 6'h17;
  localparam logic [CNT_W-1:0] ADDR_LAST_DUAL = 6'h0b;
  localparam logic [CNT_W-1:0] DUMMY_FAST     = 6'h08;
  localparam logic [CNT_W-1:0] DUMMY_DUAL_IO  = 6'h04;
  localparam logic [CNT_W-1:0] DUMMY_NONE     = 6'h00;
  localparam logic [CNT_W-1:0] WR_BITS        = 6'h08;
  localparam logic [CNT_W-1:0] CNT_MAX        = 6'h3f;
  localparam logic [2:0]       BIT_LAST_SGL   = 3'h7;
  localparam logic [2:0]       BIT_LAST_DUAL  = 3'h3;

  // ===========================================================================
  // status register field positions
  localparam int unsigned SR_WIP      = 0;
  localparam int unsigned SR_WEL      = 1;
  localparam int unsigned SR_BP_LSB   = 2;
  localparam int unsigned SR_BP_MSB   = 5;
  localparam int unsigned SR_PPB      = 7;
  localparam int unsigned SR_TB       = 3;
  localparam int unsigned SR_SECT     = 4;
  localparam int unsigned SR_OTP_LOCK = 7;

  // ===========================================================================
  // values after reset, and the address step
  localparam logic [3:0]        BP_RST   = 4'h0;
  localparam logic              PPB_RST  = 1'b0;
  localparam logic              TB_RST   = 1'b0;
  localparam logic              SECT_RST = 1'b0;
  localparam logic              OTPL_RST = 1'b0;
  localparam logic [ADDR_W-1:0] ADDR_RST = 24'h000000;
  localparam logic [ADDR_W-1:0] ADDR_ONE = 24'h000001;

  // ===========================================================================
  // timing: clock is 10 MHz; write cycle time is a plain default
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned T_W_NS        = 10000000;
  localparam int unsigned T_W_CYC       = T_W_NS / CLK_PERIOD_NS;

  // ===========================================================================
  // decoder states
  typedef enum logic [7:0] {
    ST_OPC   = 8'h01,
    ST_ADDR  = 8'h02,
    ST_DUMMY = 8'h04,
    ST_DATA  = 8'h08,
    ST_WRDAT = 8'h10,
    ST_STAT  = 8'h20,
    ST_WEN   = 8'h40,
    ST_IGN   = 8'h80
  } fsr_state_t;

endpackage : fsr_pkg

// ---- logic/fsr_wcycle.sv ----
// self-timed write cycle timer: busy for a fixed count of clock cycles
`timescale 1ns/10ps
`default_nettype none

module fsr_wcycle #(
  parameter int unsigned CYCLES = fsr_pkg::T_W_CYC
) (
  input  wire logic clk_i,
  input  wire logic nrst_i,
  input  wire logic start_i,
  output logic      busy_o,
  output logic      done_o
);
  import fsr_pkg::*;

  logic [TW_CNT_W-1:0] cnt_q;
  logic                busy_q;

  // ===========================================================================
  // countdown; a start while busy is dropped so a running cycle is untouched
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      busy_q <= 1'b0;
      cnt_q  <= '0;
    end else if (start_i && !busy_q) begin
      busy_q <= 1'b1; // R5
      cnt_q  <= TW_CNT_W'(CYCLES - 1);
    end else if (busy_q) begin
      if (cnt_q == '0) begin
        busy_q <= 1'b0; // R5
      end else begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end

  assign busy_o = busy_q;
  assign done_o = busy_q && (cnt_q == '0);

endmodule : fsr_wcycle
`default_nettype wire

// ---- logic/fsr_status.sv ----
// status register: write-enable latch, protect bits, permanent lock, one-time bits
`timescale 1ns/10ps
`default_nettype none

module fsr_status (
  input  wire logic       clk_i,
  input  wire logic       nrst_i,
  input  wire logic       otp_mode_i,
  input  wire logic       volatile_sr_en_i,
  input  wire logic       wr_i,
  input  wire logic [7:0] wr_data_i,
  input  wire logic       wel_set_i,
  input  wire logic       wel_clr_i,
  input  wire logic       wip_i,
  output logic [7:0]      status_o,
  output logic            wel_o,
  output logic [3:0]      bp_o,
  output logic            ppb_o,
  output logic            otp_lock_o,
  output logic            tb_o,
  output logic            sect_o
);
  import fsr_pkg::*;

  logic       wel_q;
  logic [3:0] bp_q;
  logic       ppb_q;
  logic       otpl_q;
  logic       tb_q;
  logic       sect_q;

  // ===========================================================================
  // write-enable latch; a set in the same cycle as a clear wins
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wel_q <= 1'b0;
    end else if (wel_set_i) begin
      wel_q <= 1'b1;
    end else if (wel_clr_i) begin
      wel_q <= 1'b0; // R7
    end
  end

  // ===========================================================================
  // normal-mode fields; bits 1:0 of the data byte are never used
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bp_q  <= BP_RST;
      ppb_q <= PPB_RST; // R9
    end else if (wr_i && !otp_mode_i && !ppb_q) begin // R9
      bp_q  <= wr_data_i[SR_BP_MSB:SR_BP_LSB]; // R8 R3
      ppb_q <= wr_data_i[SR_PPB]; // R8
    end
  end

  // ===========================================================================
  // one-time mode fields: set-only; top/bottom and size take the data byte when volatile status is enabled
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      otpl_q <= OTPL_RST;
      tb_q   <= TB_RST;
      sect_q <= SECT_RST;
    end else if (wr_i && otp_mode_i) begin
      otpl_q <= otpl_q | (wr_data_i[SR_OTP_LOCK] & ~ppb_q); // R10 R9
      if (volatile_sr_en_i) begin
        tb_q   <= wr_data_i[SR_TB];
        sect_q <= wr_data_i[SR_SECT];
      end else begin
        tb_q   <= tb_q | wr_data_i[SR_TB]; // R10
        sect_q <= sect_q | wr_data_i[SR_SECT]; // R10
      end
    end
  end

  // ===========================================================================
  // read view; reserved positions read as zero
  always_comb begin
    status_o = 8'h00;
    status_o[SR_WIP] = wip_i;
    status_o[SR_WEL] = wel_q;
    if (otp_mode_i) begin
      status_o[SR_OTP_LOCK] = otpl_q;
      status_o[SR_TB]       = tb_q;
      status_o[SR_SECT]     = sect_q;
    end else begin
      status_o[SR_BP_MSB:SR_BP_LSB] = bp_q;
      status_o[SR_PPB]              = ppb_q;
    end
  end

  assign wel_o      = wel_q;
  assign bp_o       = bp_q;
  assign ppb_o      = ppb_q;
  assign otp_lock_o = otpl_q;
  assign tb_o       = tb_q;
  assign sect_o     = sect_q;

endmodule : fsr_status
`default_nettype wire

// ---- verification/fsr_props.sv ----
// concurrent checks on the command decoder top-level ports
`timescale 1ns/10ps
`default_nettype none
module fsr_props #(
  parameter int unsigned WCYCLES = 20
) (
  input wire logic       clk_i,
  input wire logic       nrst_i,
  input wire logic       cs_n_i,
  input wire logic       sck_i,
  input wire logic       io_line_one_o,
  input wire logic       io_line_zero_oe_o,
  input wire logic       io_line_one_oe_o,
  input wire logic [7:0] status_o,
  input wire logic       write_enable_latch_o,
  input wire logic       write_in_progress_o,
  input wire logic [3:0] protect_level_o,
  input wire logic       permanent_lock_bit_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // ==========
  // length of the current busy stretch
  logic [31:0] wcnt_q;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) wcnt_q <= 32'h0;
    else wcnt_q <= write_in_progress_o ? wcnt_q + 32'h1 : 32'h0;
  end
  sequence s_cs_idle;
    cs_n_i [*4];
  endsequence
  AST_RELEASE: assert property (
    s_cs_idle |-> !io_line_one_oe_o && !io_line_zero_oe_o)
    else $error("data line driven while deselected");
  AST_MIRROR: assert property (
    status_o[1:0] == {write_enable_latch_o, write_in_progress_o})
    else $error("status low bits differ from flags");
  AST_WIP_LEN: assert property (
    $fell(write_in_progress_o) |-> wcnt_q == WCYCLES)
    else $error("write cycle length wrong");
  AST_WEL_CLR: assert property (
    $fell(write_in_progress_o) |-> !write_enable_latch_o)
    else $error("latch still set after cycle");
  AST_WIP_START: assert property (
    $rose(write_in_progress_o) |-> cs_n_i && $past(cs_n_i))
    else $error("write cycle began while selected");
  AST_LOCK: assert property (
    $past(permanent_lock_bit_o) |-> permanent_lock_bit_o && $stable(protect_level_o))
    else $error("locked bits changed");
  AST_NO_WEL: assert property (
    !$past(write_enable_latch_o) |-> $stable(protect_level_o) && $stable(permanent_lock_bit_o))
    else $error("status changed without latch");
  AST_BUSY_NODUAL: assert property (
    write_in_progress_o |-> !io_line_zero_oe_o)
    else $error("dual read driven while busy");
  AST_PAIR_OE: assert property (
    io_line_zero_oe_o |-> io_line_one_oe_o)
    else $error("line zero driven alone");
  AST_OUT_ON_FALL: assert property (
    io_line_one_oe_o && $changed(io_line_one_o) |-> $past(sck_i, 2) && !$past(sck_i))
    else $error("output changed off a serial fall");
endmodule : fsr_props
bind fsr_top fsr_props #(.WCYCLES(WCYCLES)) i_props (
  .clk_i(clk_i), .nrst_i(nrst_i), .cs_n_i(cs_n_i), .sck_i(sck_i),
  .io_line_one_o(io_line_one_o), .io_line_zero_oe_o(io_line_zero_oe_o),
  .io_line_one_oe_o(io_line_one_oe_o), .status_o(status_o),
  .write_enable_latch_o(write_enable_latch_o), .write_in_progress_o(write_in_progress_o),
  .protect_level_o(protect_level_o), .permanent_lock_bit_o(permanent_lock_bit_o));
`default_nettype wire

// ---- verification/fsr_host.sv ----
// serial host model driving select, serial clock and both data lines
`timescale 1ns/10ps
`default_nettype none
module fsr_host (
  input  wire logic clk_i,
  input  wire logic q0_i,
  input  wire logic q1_i,
  output var logic  cs_n_o,
  output var logic  sck_o,
  output var logic  d0_o,
  output var logic  d1_o,
  output var logic  oe0_o,
  output var logic  oe1_o
);
  initial begin
    cs_n_o = 1'b1;
    sck_o = 1'b0;
    d0_o = 1'b0;
    d1_o = 1'b0;
    oe0_o = 1'b0;
    oe1_o = 1'b0;
  end
  // ==========
  // one serial clock, mode 0: set while low, sample just before the rise
  task automatic cyc(input logic b1, input logic b0, output logic [1:0] s);
    sck_o = 1'b0;
    d1_o = b1;
    d0_o = b0;
    repeat (2) @(negedge clk_i);
    s = {q1_i, q0_i};
    sck_o = 1'b1;
    repeat (2) @(negedge clk_i);
  endtask : cyc
  task automatic sel();
    cs_n_o = 1'b0;
    oe0_o = 1'b1;
    repeat (2) @(negedge clk_i);
  endtask : sel
  // select rises as the clock is lowered, so the fall is masked and no partial bit follows
  task automatic desel();
    cs_n_o = 1'b1;
    sck_o = 1'b0;
    oe0_o = 1'b0;
    oe1_o = 1'b0;
    repeat (4) @(negedge clk_i);
  endtask : desel
  task automatic put(input int n, input logic [31:0] v, input bit dual);
    logic [1:0] s;
    oe1_o = dual;
    for (int i = n - 1; i >= 0; i--) begin
      if (dual) cyc(v[2*i+1], v[2*i], s);
      else cyc(~d1_o, v[i], s);
    end
  endtask : put
  // lines released before the first data fall; released lines toggle
  task automatic get(input bit dual, output logic [7:0] b);
    logic [1:0] s;
    oe0_o = 1'b0;
    oe1_o = 1'b0;
    for (int i = 0; i < (dual ? 4 : 8); i++) begin
      cyc(~d1_o, ~d0_o, s);
      b = dual ? {b[5:0], s} : {b[6:0], s[1]};
    end
  endtask : get
endmodule : fsr_host
`default_nettype wire

// ---- verification/flash_status_write_and_read_cmds_tb.sv ----
// self-checking bench for the status-write and read command decoder
`timescale 1ns/10ps
`default_nettype none
module flash_status_write_and_read_cmds_tb;
  import fsr_pkg::*;
  logic        clk_i = 1'b0;
  logic        nrst_i = 1'b0;
  logic        busy = 1'b0;
  logic        ev = 1'b0;
  logic        cs_n, sck, d0, d1, oe0, oe1, zo, zoe, oo, ooe;
  logic        otp = 1'b0, vol = 1'b0, pl, ol, tbs, ss;
  logic [3:0]  bp;
  logic [23:0] maddr, a;
  logic [7:0]  st, obs, b, d;
  logic [7:0]  q[$];
  logic [7:0]  opc[4] = '{8'h03, 8'h0b, 8'h3b, 8'hbb};
  int          dmy[4] = '{0, 8, 8, 4};
  int          bad_count = 0;
  int          checked = 0;
  int          seed = 32'hc021;
  wire logic   io0 = zoe ? zo : (oe0 ? d0 : ~d0);
  wire logic   io1 = ooe ? oo : (oe1 ? d1 : ~d1);
  always #50 clk_i = ~clk_i;
  function automatic logic [7:0] mem(input logic [23:0] x);
    return x[7:0] ^ x[23:16] ^ 8'h5a;
  endfunction : mem
  fsr_top #(.WCYCLES(200)) i_dut (
    .clk_i(clk_i), .nrst_i(nrst_i), .cs_n_i(cs_n), .sck_i(sck),
    .io_line_zero_i(io0), .io_line_one_i(io1), .io_line_zero_o(zo),
    .io_line_zero_oe_o(zoe), .io_line_one_o(oo), .io_line_one_oe_o(ooe),
    .mem_addr_o(maddr), .mem_rdata_i(mem(maddr)), .otp_mode_i(otp),
    .volatile_sr_en_i(vol), .ext_busy_i(busy), .status_o(st),
    .write_enable_latch_o(), .write_in_progress_o(), .protect_level_o(bp),
    .permanent_lock_bit_o(pl), .otp_lock_o(ol), .top_bottom_select_o(tbs),
    .sector_size_o(ss));
  fsr_host i_host (.clk_i(clk_i), .q0_i(io0), .q1_i(io1), .cs_n_o(cs_n),
    .sck_o(sck), .d0_o(d0), .d1_o(d1), .oe0_o(oe0), .oe1_o(oe1));
  // ==========
  task automatic finish_test();
    $display("TB: %0d mismatches in %0d checks", bad_count, checked);
    if (bad_count == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [7:0] o);
    obs = o;
    ev = ~ev;
    #1;
  endtask : chk
  always @(ev) begin
    logic [7:0] e;
    e = q.pop_front();
    checked++;
    if (obs !== e) begin
      bad_count++;
      $display("[FAIL] %0t got %h expected %h", $time, obs, e);
    end
  end
  task automatic cmd(input logic [7:0] op);
    i_host.sel();
    i_host.put(8, {24'h0, op}, 1'b0);
  endtask : cmd
  task automatic status_write_cmd(input bit en, input logic [7:0] v, input int n);
    if (en) begin
      cmd(OP_WRITE_UNLOCK);
      i_host.desel();
    end
    cmd(OP_WRITE_STATUS);
    i_host.put(n, {24'h0, v}, 1'b0);
    i_host.desel();
  endtask : status_write_cmd
  task automatic rdsr(input logic [7:0] e);
    cmd(OP_READ_STATUS);
    repeat (2) begin
      q.push_back(e);
      i_host.get(1'b0, b);
      chk(b);
    end
    i_host.desel();
  endtask : rdsr
  // ==========
  initial begin
    repeat (30000) @(posedge clk_i);
    bad_count++;
    finish_test();
  end
  initial begin
    repeat (2) @(negedge clk_i);
    nrst_i = 1'b1;
    @(negedge clk_i);
    q.push_back(8'h00);
    chk(st);
    status_write_cmd(1'b0, 8'h3c, 8);
    rdsr(8'h00);
    d = 8'($random(seed)) & 8'h7f;
    status_write_cmd(1'b1, d, 8);
    rdsr({2'b0, d[5:2], 2'b11});
    repeat (250) @(negedge clk_i);
    rdsr({2'b0, d[5:2], 2'b00});
    status_write_cmd(1'b1, 8'h3c, 9);
    rdsr({2'b0, d[5:2], 2'b10});
    status_write_cmd(1'b0, 8'h80, 8);
    repeat (250) @(negedge clk_i);
    rdsr(8'h80);
    status_write_cmd(1'b1, 8'h3c, 8);
    repeat (250) @(negedge clk_i);
    q.push_back(8'h80);
    chk(st);
    // one-time mode: set-once bits, lock held back by the permanent lock
    @(negedge clk_i);
    otp = 1'b1;
    for (int k = 0; k < 3; k++) begin
      vol = (k == 2);
      status_write_cmd(1'b1, (k == 0) ? 8'h98 : 8'h00, 8);
      repeat (250) @(negedge clk_i);
      rdsr((k == 2) ? 8'h00 : 8'h18);
      if (k == 0) begin
        q.push_back(8'hb0);
        chk({pl, ol, tbs, ss, bp});
      end
    end
    otp = 1'b0;
    // dummy clocks carry random data, which must be ignored
    for (int i = 0; i < 4; i++) begin
      a = (i == 0) ? 24'hffffff : 24'($random(seed));
      cmd(opc[i]);
      i_host.put(i == 3 ? 12 : 24, {8'h0, a}, i == 3);
      if (dmy[i] != 0) i_host.put(dmy[i], $random(seed), i == 3);
      repeat (2) begin
        q.push_back(mem(a));
        a = a + 24'h1;
        i_host.get(i >= 2, b);
        chk(b);
      end
      i_host.desel();
    end
    busy = 1'b1;
    cmd(OP_READ);
    i_host.put(24, 32'h0, 1'b0);
    q.push_back(8'h00);
    i_host.get(1'b0, b);
    chk({7'h0, ooe | zoe});
    i_host.desel();
    busy = 1'b0;
    finish_test();
  end
endmodule : flash_status_write_and_read_cmds_tb
`default_nettype wire
